// ---- logic/rts_pkg.sv ----
package rts_pkg;
	localparam int RTS_CLK_PERIOD_NS = 10;
	localparam int RTS_US_NS         = 1000;
	localparam int RTS_TICK_CYC      = (RTS_US_NS + RTS_CLK_PERIOD_NS - 1) / RTS_CLK_PERIOD_NS;
	localparam int RTS_PUD_MS        = 72;
	localparam int RTS_PLL_MS        = 2;
	localparam int RTS_OSU_CYCLES    = 1024;
	localparam int RTS_EXT_REC_NS    = 1500;
	localparam int RTS_EXT_REC_CYC   = (RTS_EXT_REC_NS + RTS_CLK_PERIOD_NS - 1) / RTS_CLK_PERIOD_NS;
	localparam int RTS_PIN_FILT_CYC  = 4;
	localparam int RTS_PC_W          = 21;
	localparam logic [7:0] RTS_ADDR_CAUSE = 8'h00;
	localparam logic [7:0] RTS_ADDR_CFG   = 8'h04;
	localparam logic [7:0] RTS_ADDR_STAT  = 8'h08;
	localparam logic [7:0] RTS_CAUSE_POR  = 8'h1c;
	localparam logic [7:0] RTS_CAUSE_WMSK = 8'h9f;
	localparam logic [7:0] RTS_CFG_RST    = 8'h22;
	localparam logic [7:0] RTS_CFG_WMSK   = 8'h3f;
	localparam logic [2:0] RTS_MODE_LOWPWR  = 3'h0;
	localparam logic [2:0] RTS_MODE_STDXTAL = 3'h1;
	localparam logic [2:0] RTS_MODE_HISPD   = 3'h2;
	localparam logic [2:0] RTS_MODE_EXTCLK  = 3'h3;
	localparam logic [2:0] RTS_MODE_RESCAP  = 3'h4;
	localparam logic [20:0] RTS_VEC_RESET = 21'h000000;
	localparam logic [20:0] RTS_VEC_HIGH  = 21'h000008;
	localparam logic [20:0] RTS_VEC_LOW   = 21'h000018;
	localparam logic [20:0] RTS_PC_STEP   = 21'h000002;
	localparam logic [1:0] RTS_RESP_OKAY   = 2'b00;
	localparam logic [1:0] RTS_RESP_SLVERR = 2'b10;
	typedef struct packed {
		logic       irq_priority_enable;
		logic [1:0] unimpl;
		logic       reset_instr_flag;
		logic       timeout_flag_n;
		logic       powerdown_flag_n;
		logic       poweron_flag_n;
		logic       brownout_flag_n;
	} rts_cause_t;
	typedef struct packed {
		logic [1:0] unimpl;
		logic       brownout_enable_bit;
		logic       power_up_timer_enable_n;
		logic       pll_enable;
		logic [2:0] osc_mode;
	} rts_cfg_t;
	typedef enum logic [2:0] {
		RTS_RUN  = 3'b000,
		RTS_HOLD = 3'b001,
		RTS_PUD  = 3'b010,
		RTS_OSU  = 3'b011,
		RTS_PLL  = 3'b100,
		RTS_ECW  = 3'b101
	} rts_state_t;
	typedef enum logic [1:0] {
		RTS_PATH_POR  = 2'b00,
		RTS_PATH_BRN  = 2'b01,
		RTS_PATH_WAKE = 2'b10
	} rts_path_t;
endpackage

// ---- logic/rts_top.sv ----
`timescale 1ns/1ps
// Contract
// - start-up count 1024 osc cycles after delay
// - start-up count: crystal modes, power-on or wake
// - power-up delay on power-on and brown-out, 72 ms
// - power-up delay inserted when enable_n is zero
// - lock wait 2 ms after start-up count
// - brown-out detection gated by enable bit
// - stay in brown-out reset until supply returns
// - after brown-out rerun delay, restart on dip
// - order: power-up delay, start-up count, lock wait
// - resistor mode, delay off: no time-out
// - time-outs ignore master clear, release immediate
// - external clock wake, or power-on with delay off: 1.5 us
// - external clock oscillator switch adds no delay
// - cause register layout, eight bits
// - power-on sets PC zero, flags 1c
// - master clear while awake keeps all flags
// - software reset clears reset-instruction flag
// - stack resets set their stack flag
// - master clear in sleep: timeout set, powerdown clear
// - interrupt wake: PC+2, timeout set, powerdown clear
// - enabled interrupt wake loads priority vector
// - master clear never driven, glitches filtered
module rts_top #(
	parameter int PUD_TICKS   = rts_pkg::RTS_PUD_MS * 1000,
	parameter int PLL_TICKS   = rts_pkg::RTS_PLL_MS * 1000,
	parameter int OSU_CYCLES  = rts_pkg::RTS_OSU_CYCLES,
	parameter int PIN_FILT    = rts_pkg::RTS_PIN_FILT_CYC
) (
	// Clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// Supervisor, pin and oscillator
	input  wire logic                         brownout_low,
	input  wire logic                         master_clear_pin_n,
	input  wire logic                         osc_in,
	// Core events
	input  wire logic                         core_sleeping,
	input  wire logic                         sw_reset_req,
	input  wire logic                         stack_full_req,
	input  wire logic                         stack_under_req,
	input  wire logic                         wdt_timeout,
	input  wire logic                         irq_wake,
	input  wire logic                         irq_is_high,
	input  wire logic                         global_high_irq_enable,
	input  wire logic                         global_low_irq_enable,
	input  wire logic [rts_pkg::RTS_PC_W-1:0] pc_current,
	// Core control
	output logic                              core_hold,
	output logic                              pc_load,
	output logic [rts_pkg::RTS_PC_W-1:0]      pc_load_value,
	// AXI4-Lite slave
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [7:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready
);
	import rts_pkg::*;

	localparam int CNT_W = $clog2(PUD_TICKS + PLL_TICKS + OSU_CYCLES + RTS_EXT_REC_CYC + 1);
	localparam int PRE_W = $clog2(RTS_TICK_CYC + 1);
	localparam int FLT_W = $clog2(PIN_FILT + 1);

	rts_state_t        state_r;
	rts_state_t        state_nxt;
	rts_path_t         path_r;
	rts_path_t         path_nxt;
	rts_cause_t        reset_cause_control_r;
	rts_cfg_t          cfg_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [PRE_W-1:0]  pre_r;
	logic [FLT_W-1:0]  flt_r;
	logic              pin_low_r;
	logic              pin_ev;
	logic              osc_q_r;
	logic              osc_rise;
	logic              us_tick;
	logic              tdone;
	logic              brown_on;
	logic              wake_ev;
	logic              wdt_rst_ev;
	logic              wdt_wake_ev;
	logic              irq_wake_ev;
	logic              sw_ev;
	logic              rst_ev;
	logic              pend_r;
	logic              pc_go;
	logic              stk_full_r;
	logic              stk_under_r;
	logic              aw_full_r;
	logic              w_full_r;
	logic [7:0]        awaddr_r;
	logic [7:0]        wdata_r;
	logic              wstrb0_r;
	logic              do_write;

	function automatic logic crystal(input logic [2:0] mode);
		return mode == RTS_MODE_LOWPWR || mode == RTS_MODE_STDXTAL || mode == RTS_MODE_HISPD;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == RTS_ADDR_CAUSE || a == RTS_ADDR_CFG || a == RTS_ADDR_STAT;
	endfunction

	// Next step once the power-up delay is over or was skipped.
	function automatic rts_state_t after_pud(input logic [2:0] mode, input logic pud_off);
		if (crystal(mode)) begin
			return RTS_OSU;
		end else if (mode == RTS_MODE_EXTCLK && pud_off) begin
			return RTS_ECW;
		end
		return RTS_RUN;
	endfunction

	// The pin is never driven from here; resets act on core_hold and the PC load only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flt_r      <= '0;
			pin_low_r  <= 1'b0;
		end else if (master_clear_pin_n == !pin_low_r) begin
			flt_r <= '0;
		end else if (flt_r == FLT_W'(PIN_FILT - 1)) begin
			flt_r      <= '0;
			pin_low_r  <= !master_clear_pin_n;
		end else begin
			flt_r <= flt_r + 1'b1;
		end
	end

	assign pin_ev = (flt_r == FLT_W'(PIN_FILT - 1)) && !master_clear_pin_n && !pin_low_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_q_r <= 1'b0;
		end else begin
			osc_q_r <= osc_in;
		end
	end

	assign osc_rise    = osc_in && !osc_q_r;
	assign us_tick     = pre_r == PRE_W'(RTS_TICK_CYC - 1);
	assign brown_on    = cfg_r.brownout_enable_bit && brownout_low;
	assign wake_ev     = state_r == RTS_RUN && core_sleeping && (irq_wake || wdt_timeout) && !brown_on;
	assign wdt_wake_ev = wake_ev && wdt_timeout;
	assign irq_wake_ev = wake_ev && !wdt_timeout;
	assign wdt_rst_ev  = wdt_timeout && !core_sleeping && state_r == RTS_RUN;
	assign sw_ev       = sw_reset_req && !core_sleeping;
	assign rst_ev      = brown_on || pin_ev || sw_ev || stack_full_req || stack_under_req || wdt_rst_ev;
	assign pc_go       = state_r == RTS_RUN && !pin_low_r && pend_r && !rst_ev && !wake_ev;

	always_comb begin
		tdone = 1'b0;
		unique case (state_r)
			RTS_PUD:  tdone = us_tick && cnt_r == CNT_W'(PUD_TICKS - 1);
			RTS_PLL:  tdone = us_tick && cnt_r == CNT_W'(PLL_TICKS - 1);
			RTS_OSU:  tdone = osc_rise && cnt_r == CNT_W'(OSU_CYCLES - 1);
			RTS_ECW:  tdone = cnt_r == CNT_W'(RTS_EXT_REC_CYC - 1);
			default:  tdone = 1'b0;
		endcase
	end

	// Master clear is not looked at here, so the time-outs run while the pin is low.
	always_comb begin
		state_nxt = state_r;
		path_nxt  = path_r;
		if (brown_on) begin
			state_nxt = RTS_HOLD;
			path_nxt  = RTS_PATH_BRN;
		end else begin
			unique case (state_r)
				RTS_HOLD: begin
					if (!cfg_r.power_up_timer_enable_n) begin
						state_nxt = RTS_PUD;
					end else if (path_r == RTS_PATH_POR) begin
						state_nxt = after_pud(cfg_r.osc_mode, 1'b1);
					end else begin
						state_nxt = RTS_RUN;
					end
				end
				RTS_PUD: if (tdone) begin
					state_nxt = path_r == RTS_PATH_POR ? after_pud(cfg_r.osc_mode, 1'b0) : RTS_RUN;
				end
				RTS_OSU: if (tdone) begin
					state_nxt = cfg_r.pll_enable && cfg_r.osc_mode == RTS_MODE_HISPD ? RTS_PLL : RTS_RUN;
				end
				RTS_PLL, RTS_ECW: if (tdone) begin
					state_nxt = RTS_RUN;
				end
				RTS_RUN: if (wake_ev) begin
					// An oscillator switch alone never enters a wait state.
					path_nxt = RTS_PATH_WAKE;
					if (crystal(cfg_r.osc_mode)) begin
						state_nxt = RTS_OSU;
					end else if (cfg_r.osc_mode == RTS_MODE_EXTCLK) begin
						state_nxt = RTS_ECW;
					end
				end
				default: state_nxt = RTS_HOLD;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= RTS_HOLD;
			path_r  <= RTS_PATH_POR;
		end else begin
			state_r <= state_nxt;
			path_r  <= path_nxt;
		end
	end

	// Restarting the prescaler on entry keeps every delay at its full length.
	always_ff @(posedge aclk) begin
		if (!aresetn || state_nxt != state_r || brown_on) begin
			cnt_r <= '0;
			pre_r <= '0;
		end else begin
			pre_r <= us_tick ? '0 : pre_r + 1'b1;
			if ((state_r == RTS_OSU && osc_rise) || state_r == RTS_ECW ||
			    ((state_r == RTS_PUD || state_r == RTS_PLL) && us_tick)) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// Hardware events win over a software write in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_cause_control_r <= RTS_CAUSE_POR;
		end else if (brown_on) begin
			reset_cause_control_r.reset_instr_flag <= 1'b1;
			reset_cause_control_r.timeout_flag_n   <= 1'b1;
			reset_cause_control_r.powerdown_flag_n <= 1'b1;
			reset_cause_control_r.brownout_flag_n  <= 1'b0;
		end else if (pin_ev && core_sleeping) begin
			reset_cause_control_r.timeout_flag_n   <= 1'b1;
			reset_cause_control_r.powerdown_flag_n <= 1'b0;
		end else if (wdt_rst_ev) begin
			reset_cause_control_r.reset_instr_flag <= 1'b1;
			reset_cause_control_r.timeout_flag_n   <= 1'b0;
			reset_cause_control_r.powerdown_flag_n <= 1'b1;
		end else if (wdt_wake_ev) begin
			reset_cause_control_r.timeout_flag_n   <= 1'b0;
			reset_cause_control_r.powerdown_flag_n <= 1'b0;
		end else if (irq_wake_ev) begin
			reset_cause_control_r.timeout_flag_n   <= 1'b1;
			reset_cause_control_r.powerdown_flag_n <= 1'b0;
		end else if (sw_ev) begin
			reset_cause_control_r.reset_instr_flag <= 1'b0;
		end else if (do_write && awaddr_r == RTS_ADDR_CAUSE && wstrb0_r) begin
			reset_cause_control_r <= wdata_r & RTS_CAUSE_WMSK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= RTS_CFG_RST;
		end else if (do_write && awaddr_r == RTS_ADDR_CFG && wstrb0_r) begin
			cfg_r <= wdata_r & RTS_CFG_WMSK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stk_full_r  <= 1'b0;
			stk_under_r <= 1'b0;
		end else begin
			if (stack_full_req) begin
				stk_full_r <= 1'b1;
			end else if (do_write && awaddr_r == RTS_ADDR_STAT && wstrb0_r && wdata_r[0]) begin
				stk_full_r <= 1'b0;
			end
			if (stack_under_req) begin
				stk_under_r <= 1'b1;
			end else if (do_write && awaddr_r == RTS_ADDR_STAT && wstrb0_r && wdata_r[1]) begin
				stk_under_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_r        <= 1'b1;
			pc_load_value <= RTS_VEC_RESET;
		end else if (rst_ev) begin
			pend_r        <= 1'b1;
			pc_load_value <= RTS_VEC_RESET;
		end else if (wake_ev) begin
			pend_r        <= 1'b1;
			pc_load_value <= pc_current + RTS_PC_STEP;
			if (irq_wake_ev && (global_high_irq_enable || global_low_irq_enable)) begin
				pc_load_value <= irq_is_high ? RTS_VEC_HIGH : RTS_VEC_LOW;
			end
		end else if (pc_go) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_load   <= 1'b0;
			core_hold <= 1'b1;
		end else begin
			pc_load   <= pc_go;
			core_hold <= state_nxt != RTS_RUN || pin_low_r || rst_ev || wake_ev || (pend_r && !pc_go);
		end
	end

	assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			awaddr_r      <= '0;
			wdata_r       <= '0;
			wstrb0_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RTS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r     <= 1'b1;
				wdata_r      <= s_axi_wdata[7:0];
				wstrb0_r     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awaddr_r) ? RTS_RESP_OKAY : RTS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_full_r     <= 1'b0;
				w_full_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RTS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= mapped(s_axi_araddr) ? RTS_RESP_OKAY : RTS_RESP_SLVERR;
			s_axi_rdata   <= '0;
			unique case (s_axi_araddr)
				RTS_ADDR_CAUSE: s_axi_rdata[7:0] <= reset_cause_control_r & RTS_CAUSE_WMSK;
				RTS_ADDR_CFG:   s_axi_rdata[7:0] <= cfg_r;
				RTS_ADDR_STAT:  s_axi_rdata[6:0] <= {core_hold, state_r, 1'b0, stk_under_r, stk_full_r};
				default:        s_axi_rdata <= '0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	a_osu_len: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == RTS_OSU && state_nxt != RTS_OSU && !brown_on) |-> cnt_r == CNT_W'(OSU_CYCLES - 1))
		else $error("start-up count left early");
	a_osu_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_nxt == RTS_OSU && state_r != RTS_OSU) |-> crystal(cfg_r.osc_mode) && path_nxt != RTS_PATH_BRN)
		else $error("start-up count entered outside crystal power-on or wake");
	a_pud_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state_r == RTS_PUD) |-> $past(!cfg_r.power_up_timer_enable_n))
		else $error("power-up delay ran while disabled");
	a_pll_order: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state_r == RTS_PLL) |-> $past(state_r) == RTS_OSU)
		else $error("lock wait not after start-up count");
	a_brown_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		brown_on |=> state_r == RTS_HOLD && core_hold && cnt_r == '0)
		else $error("brown-out not holding reset");
	a_ext_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == RTS_ECW && state_nxt == RTS_RUN) |-> cnt_r == CNT_W'(RTS_EXT_REC_CYC - 1))
		else $error("external clock recovery length wrong");
	a_pin_release: assert property (@(posedge aclk) disable iff (!aresetn)
		(pc_go && $fell(pin_low_r)) |=> pc_load ##1 !core_hold)
		else $error("release after master clear delayed");
	a_sw_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(sw_ev && !brown_on && !pin_ev && !wdt_rst_ev && !wake_ev) |=> !reset_cause_control_r.reset_instr_flag && pend_r)
		else $error("software reset flag not cleared");
	a_irq_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		(irq_wake_ev && !rst_ev && global_high_irq_enable && irq_is_high) |=> pc_load_value == RTS_VEC_HIGH)
		else $error("high vector not loaded");
	a_por_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> reset_cause_control_r == RTS_CAUSE_POR && pc_load_value == RTS_VEC_RESET && core_hold)
		else $error("power-on flags wrong");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule

// ---- bench/rts_tb_top.sv ----
`timescale 1ns/1ps
module rts_tb_top;
	import rts_pkg::*;
	localparam int PW = 3;
	logic                aclk = 1'b0, aresetn = 1'b0, brownout_low = 1'b0, master_clear_pin_n = 1'b1;
	logic                osc_in = 1'b0, core_sleeping = 1'b0, sw_reset_req = 1'b0, stack_full_req = 1'b0;
	logic                stack_under_req = 1'b0, wdt_timeout = 1'b0, irq_wake = 1'b0, irq_is_high = 1'b0;
	logic                global_high_irq_enable = 1'b0, global_low_irq_enable = 1'b0;
	logic [RTS_PC_W-1:0] pc_current = 21'h000100;
	logic                core_hold, pc_load;
	logic [RTS_PC_W-1:0] pc_load_value, lpc;
	logic [7:0]          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]         s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]          s_axi_wstrb = 4'hf;
	logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	logic [2:0]          oc = 3'h0;
	int                  cyc = 0, load_cnt = 0, tl = 0, seen = 0, t0 = 0, mismatches = 0, cmp_count = 0;
	logic [7:0]          wc[4] = '{8'h22, 8'h2a, 8'h23, 8'h24};
	logic [1:0]          wg[4] = '{2'b00, 2'b10, 2'b01, 2'b00};
	logic                wh[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic [20:0]         wp[4] = '{21'h000102, RTS_VEC_HIGH, RTS_VEC_LOW, 21'h000102};
	logic [7:0]          wr[4] = '{8'h9b, 8'h9b, 8'h9b, 8'h93};
	int                  wlo[4] = '{24, 224, 150, 0};
	int                  whi[4] = '{45, 250, 160, 5};

	rts_top #(.PUD_TICKS(PW), .PLL_TICKS(2), .OSU_CYCLES(4), .PIN_FILT(4)) DUT (
		.aclk, .aresetn, .brownout_low, .master_clear_pin_n, .osc_in, .core_sleeping, .sw_reset_req,
		.stack_full_req, .stack_under_req, .wdt_timeout, .irq_wake, .irq_is_high, .global_high_irq_enable,
		.global_low_irq_enable, .pc_current, .core_hold, .pc_load, .pc_load_value, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	always #5 aclk = ~aclk;

	// The oscillator runs at one eighth of aclk, well below the sampling limit.
	always @(posedge aclk) begin
		oc <= oc + 3'h1;
		osc_in <= oc[2];
		cyc <= cyc + 1;
		if (pc_load === 1'b1) begin
			load_cnt <= load_cnt + 1;
			lpc <= pc_load_value;
			tl <= cyc;
		end
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic tmo();
		mismatches++;
		$display("BAD wait exp 1 seen 0");
		complete_run();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) tmo();
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) tmo();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk(nm, d & m, e);
	endtask

	task automatic wst(input rts_state_t st);
		logic [31:0] d;
		logic [1:0]  r;
		for (int n = 0; n < 300; n++) begin
			axr(RTS_ADDR_STAT, d, r);
			if (d[5:3] === st) break;
		end
		chk("state", {29'h0, d[5:3]}, {29'h0, st});
	endtask

	task automatic ev(input int k);
		@(posedge aclk);
		case (k)
			0: sw_reset_req <= 1'b1;
			1: stack_full_req <= 1'b1;
			2: stack_under_req <= 1'b1;
			3: wdt_timeout <= 1'b1;
			default: irq_wake <= 1'b1;
		endcase
		t0 = cyc;
		@(posedge aclk);
		{sw_reset_req, stack_full_req, stack_under_req, wdt_timeout, irq_wake} <= 5'h00;
	endtask

	task automatic wld(input logic [20:0] pc);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if (load_cnt != seen) break;
		end
		if (n == 3000) tmo();
		seen = load_cnt;
		chk("pc", {11'h0, lpc}, {11'h0, pc});
	endtask

	task automatic rng(input int lo, input int hi);
		chk("delay", {31'h0, (tl - t0 >= lo) && (tl - t0 <= hi)}, 32'h1);
	endtask

	task automatic tend(input string nm);
		$display("test %0s done", nm);
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t0 = cyc;
		wst(RTS_PUD);
		wst(RTS_OSU);
		wld(RTS_VEC_RESET);
		rng(PW * RTS_TICK_CYC, PW * RTS_TICK_CYC + 45);
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h1c, "cause");
		rdm(RTS_ADDR_CFG, 32'hff, 32'h22, "cfg");
		chk("hold", {31'h0, core_hold}, 32'h0);
		tend("power_on");
		axw(8'h0c, 32'h1, r);
		chk("bresp", {30'h0, r}, {30'h0, RTS_RESP_SLVERR});
		axr(8'h0c, d, r);
		chk("rresp", {30'h0, r}, {30'h0, RTS_RESP_SLVERR});
		chk("rdata", d, 32'h0);
		axw(RTS_ADDR_CAUSE, 32'hff, r);
		rdm(RTS_ADDR_CAUSE, 32'hffffffff, 32'h9f, "cause");
		axw(RTS_ADDR_CAUSE, 32'h93, r);
		ev(0);
		wld(RTS_VEC_RESET);
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h83, "cause");
		ev(1);
		wld(RTS_VEC_RESET);
		rdm(RTS_ADDR_STAT, 32'h3, 32'h1, "stack");
		ev(2);
		wld(RTS_VEC_RESET);
		rdm(RTS_ADDR_STAT, 32'h3, 32'h3, "stack");
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h83, "cause");
		axw(RTS_ADDR_STAT, 32'h3, r);
		rdm(RTS_ADDR_STAT, 32'h3, 32'h0, "stack");
		tend("soft_resets");
		master_clear_pin_n <= 1'b0;
		repeat (2) @(posedge aclk);
		master_clear_pin_n <= 1'b1;
		repeat (20) @(posedge aclk);
		chk("glitch", load_cnt, seen);
		master_clear_pin_n <= 1'b0;
		repeat (10) @(posedge aclk);
		chk("hold", {31'h0, core_hold}, 32'h1);
		master_clear_pin_n <= 1'b1;
		wld(RTS_VEC_RESET);
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h83, "cause");
		ev(3);
		wld(RTS_VEC_RESET);
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h97, "cause");
		tend("pin_and_watchdog");
		for (int i = 0; i < 4; i++) begin
			axw(RTS_ADDR_CFG, {24'h0, wc[i]}, r);
			{global_high_irq_enable, global_low_irq_enable} <= wg[i];
			irq_is_high <= wh[i];
			core_sleeping <= 1'b1;
			ev(i == 3 ? 3 : 4);
			wld(wp[i]);
			core_sleeping <= 1'b0;
			rng(wlo[i], whi[i]);
			rdm(RTS_ADDR_CAUSE, 32'hff, {24'h0, wr[i]}, "cause");
		end
		tend("wake");
		// A second dip in mid-delay must restart the whole power-up delay.
		axw(RTS_ADDR_CFG, 32'h22, r);
		axw(RTS_ADDR_CAUSE, 32'h83, r);
		brownout_low <= 1'b1;
		repeat (5) @(posedge aclk);
		chk("hold", {31'h0, core_hold}, 32'h1);
		rdm(RTS_ADDR_STAT, 32'h38, {26'h0, RTS_HOLD, 3'h0}, "state");
		brownout_low <= 1'b0;
		wst(RTS_PUD);
		brownout_low <= 1'b1;
		repeat (3) @(posedge aclk);
		brownout_low <= 1'b0;
		t0 = cyc;
		wld(RTS_VEC_RESET);
		rng(PW * RTS_TICK_CYC, PW * RTS_TICK_CYC + 45);
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h9e, "cause");
		axw(RTS_ADDR_CFG, 32'h02, r);
		brownout_low <= 1'b1;
		repeat (10) @(posedge aclk);
		chk("hold", {31'h0, core_hold}, 32'h0);
		brownout_low <= 1'b0;
		chk("loads", load_cnt, seen);
		axw(RTS_ADDR_CFG, 32'h34, r);
		brownout_low <= 1'b1;
		repeat (3) @(posedge aclk);
		brownout_low <= 1'b0;
		t0 = cyc;
		wld(RTS_VEC_RESET);
		rng(0, 5);
		tend("brown_out");
		master_clear_pin_n <= 1'b0;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (600) @(posedge aclk);
		master_clear_pin_n <= 1'b1;
		t0 = cyc;
		wld(RTS_VEC_RESET);
		rng(0, 9);
		rdm(RTS_ADDR_CAUSE, 32'hff, 32'h1c, "cause");
		tend("pin_held_at_power_on");
		complete_run();
	end
endmodule
